// File: gse_top.sv
// graphics engine setup registers, trigger logic and pixel stepper
// Functional notes
// RULE_01: writing the line trigger register starts a line with current parameters
// RULE_02: writing the block trigger register starts a block transfer with current parameters
// RULE_03: status register keeps configuration; status flags live in the low byte
// RULE_04: destination upper half is signed Y, destination or line start
// RULE_05: destination lower half is signed X, destination or line start
// RULE_06: block width is size upper half; zero width renders nothing
// RULE_07: line length is 14 bits; size bits 31 and 30 are ignored
// RULE_08: block height is size lower half; zero height renders nothing
// RULE_09: in line mode size lower half is the initial error term
// RULE_10: source upper half is signed source X or axial error increment
// RULE_11: source lower half is signed source Y or diagonal error increment
// RULE_12: legacy window register holds legacy display offset in graphics memory
// RULE_13: legacy latch register reads and writes the legacy display latch
// RULE_14: parameter, trigger and status registers read zero after reset
// RULE_15: parameter registers keep their values after an operation starts
`timescale 1ns/1ps
module gse_top (
   input  wire logic        clk_sys,              // system clock, 200 MHz
   input  wire logic        rst_n,                // asynchronous reset, active low
   input  wire logic [15:0] reg_addr,             // byte offset from graphics base
   input  wire logic        reg_wr,               // write strobe
   input  wire logic        reg_rd,               // read strobe
   input  wire logic [3:0]  reg_be,               // byte enables of a write
   input  wire logic [31:0] reg_wdata,            // write data
   output logic      [31:0] reg_rdata,            // read data, one cycle after reg_rd
   output logic             reg_rvalid,           // read data valid pulse
   output logic      [31:0] legacy_window_offset, // legacy display window offset
   output logic             latch_wr_pulse,       // load pulse to legacy latch
   output logic      [31:0] latch_wdata,          // data for legacy latch
   input  wire logic [31:0] latch_rdata,          // current legacy latch contents
   output logic             pix_valid,            // pixel request valid
   input  wire logic        pix_ready,            // pixel sink accepts
   output logic             pix_line,             // pixel belongs to a line
   output logic      [15:0] pix_x,                // destination x, signed
   output logic      [15:0] pix_y,                // destination y, signed
   output logic      [15:0] pix_src_x,            // source x, signed
   output logic      [15:0] pix_src_y             // source y, signed
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_sync_reg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // byte lane mask
   // ------------------------------------------------------------
   logic [31:0] wmask;

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : g_lane
         assign wmask[lane*8 +: 8] = {8{reg_be[lane]}};
      end
   endgenerate

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0]        dest_reg,    dest_next;
   logic [31:0]        size_reg,    size_next;
   logic [31:0]        source_reg,  source_next;
   logic [31:0]        line_reg,    line_next;
   logic [31:0]        block_reg,   block_next;
   logic [31:0]        cfg_reg,     cfg_next;
   logic               refused_reg, refused_next;
   logic [31:0]        window_reg,  window_next;
   logic [31:0]        latchw_reg,  latchw_next;
   logic               latchp_reg,  latchp_next;
   logic [31:0]        rdata_reg,   rdata_next;
   logic               rvalid_reg,  rvalid_next;
   gse_pkg::gse_state_t state_reg,  state_next;
   logic [15:0]        x_reg,       x_next;
   logic [15:0]        y_reg,       y_next;
   logic [15:0]        sx_reg,      sx_next;
   logic [15:0]        sy_reg,      sy_next;
   logic [15:0]        col_reg,     col_next;
   logic [15:0]        row_reg,     row_next;
   logic [15:0]        w_reg,       w_next;
   logic [15:0]        h_reg,       h_next;
   logic [15:0]        x0_reg,      x0_next;
   logic [15:0]        sx0_reg,     sx0_next;
   logic signed [15:0] err_reg,     err_next;
   logic [15:0]        axial_reg,   axial_next;
   logic [15:0]        diag_reg,    diag_next;
   logic [2:0]         dir_reg,     dir_next;

   logic        wr_hit;
   logic        idle;
   logic [31:0] status_word;
   logic [15:0] line_len;
   logic [15:0] xstep;
   logic [15:0] ystep;

   assign idle        = (state_reg == gse_pkg::GSE_IDLE);
   assign line_len    = {2'h0, size_reg[gse_pkg::LEN_MSB:gse_pkg::HI_LSB]};      // see RULE_07
   assign xstep       = dir_reg[gse_pkg::LINE_X_NEG] ? 16'hFFFF : 16'h0001;
   assign ystep       = dir_reg[gse_pkg::LINE_Y_NEG] ? 16'hFFFF : 16'h0001;
   assign wr_hit      = reg_wr;

   // status flags in the low byte, configuration above it
   always_comb begin
      status_word                      = {cfg_reg[31:gse_pkg::CFG_LSB], 8'h00}; // see RULE_03
      status_word[gse_pkg::ST_BUSY]    = !idle;
      status_word[gse_pkg::ST_BLOCK]   = (state_reg == gse_pkg::GSE_BLOCK);
      status_word[gse_pkg::ST_LINE]    = (state_reg == gse_pkg::GSE_LINE);
      status_word[gse_pkg::ST_REFUSED] = refused_reg;
   end

   // ------------------------------------------------------------
   // next values
   // ------------------------------------------------------------
   always_comb begin
      dest_next    = dest_reg;
      size_next    = size_reg;
      source_next  = source_reg;
      line_next    = line_reg;
      block_next   = block_reg;
      cfg_next     = cfg_reg;
      refused_next = refused_reg;
      window_next  = window_reg;
      latchw_next  = latchw_reg;
      latchp_next  = 1'b0;
      rdata_next   = rdata_reg;
      rvalid_next  = reg_rd;
      state_next   = state_reg;
      x_next       = x_reg;
      y_next       = y_reg;
      sx_next      = sx_reg;
      sy_next      = sy_reg;
      col_next     = col_reg;
      row_next     = row_reg;
      w_next       = w_reg;
      h_next       = h_reg;
      x0_next      = x0_reg;
      sx0_next     = sx0_reg;
      err_next     = err_reg;
      axial_next   = axial_reg;
      diag_next    = diag_reg;
      dir_next     = dir_reg;

      // pixel stepping
      unique case (state_reg)
         gse_pkg::GSE_IDLE: begin
         end
         gse_pkg::GSE_BLOCK: begin
            if (pix_ready) begin
               if (col_reg == w_reg - 16'h0001) begin
                  col_next = 16'h0000;
                  x_next   = x0_reg;
                  sx_next  = sx0_reg;
                  y_next   = y_reg + 16'h0001;
                  sy_next  = sy_reg + 16'h0001;
                  row_next = row_reg + 16'h0001;
                  if (row_reg == h_reg - 16'h0001) begin
                     state_next = gse_pkg::GSE_IDLE;
                  end
               end else begin
                  col_next = col_reg + 16'h0001;
                  x_next   = x_reg + 16'h0001;
                  sx_next  = sx_reg + 16'h0001;
               end
            end
         end
         gse_pkg::GSE_LINE: begin
            if (pix_ready) begin
               col_next = col_reg - 16'h0001;
               if (col_reg == 16'h0001) begin
                  state_next = gse_pkg::GSE_IDLE;
               end
               // major axis steps always, minor axis on a diagonal step
               if (dir_reg[gse_pkg::LINE_Y_MAJOR] || !err_reg[15]) begin
                  y_next = y_reg + ystep;
               end
               if (!dir_reg[gse_pkg::LINE_Y_MAJOR] || !err_reg[15]) begin
                  x_next = x_reg + xstep;
               end
               if (!err_reg[15]) begin
                  err_next = err_reg + $signed(diag_reg);                      // see RULE_11
               end else begin
                  err_next = err_reg + $signed(axial_reg);                     // see RULE_10
               end
            end
         end
      endcase

      // register writes, parameters are copied so they survive a start
      if (wr_hit) begin
         unique case (reg_addr)
            gse_pkg::OFS_DEST_START: begin
               dest_next = (dest_reg & ~wmask) | (reg_wdata & wmask);          // see RULE_15
            end
            gse_pkg::OFS_SIZE_LENGTH: begin
               size_next = (size_reg & ~wmask) | (reg_wdata & wmask);
            end
            gse_pkg::OFS_SOURCE_ERROR: begin
               source_next = (source_reg & ~wmask) | (reg_wdata & wmask);
            end
            gse_pkg::OFS_LINE_TRIGGER: begin
               line_next = (line_reg & ~wmask) | (reg_wdata & wmask);
               if (!idle) begin
                  refused_next = 1'b1;
               end else if (line_len != 16'h0000) begin                        // see RULE_01
                  state_next = gse_pkg::GSE_LINE;
                  x_next     = dest_reg[gse_pkg::LO_MSB:0];                    // see RULE_05
                  y_next     = dest_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB];      // see RULE_04
                  col_next   = line_len;                                       // see RULE_07
                  err_next   = $signed(size_reg[gse_pkg::LO_MSB:0]);           // see RULE_09
                  axial_next = source_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB];    // see RULE_10
                  diag_next  = source_reg[gse_pkg::LO_MSB:0];                  // see RULE_11
                  dir_next   = line_next[2:0];
               end
            end
            gse_pkg::OFS_BLOCK_TRIGGER: begin
               block_next = (block_reg & ~wmask) | (reg_wdata & wmask);
               if (!idle) begin
                  refused_next = 1'b1;
               end else if (size_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB] != 16'h0000 // see RULE_06
                            && size_reg[gse_pkg::LO_MSB:0] != 16'h0000) begin  // see RULE_08
                  state_next = gse_pkg::GSE_BLOCK;                             // see RULE_02
                  x_next     = dest_reg[gse_pkg::LO_MSB:0];                    // see RULE_05
                  y_next     = dest_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB];      // see RULE_04
                  x0_next    = dest_reg[gse_pkg::LO_MSB:0];
                  sx_next    = source_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB];    // see RULE_10
                  sx0_next   = source_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB];
                  sy_next    = source_reg[gse_pkg::LO_MSB:0];                  // see RULE_11
                  w_next     = size_reg[gse_pkg::HI_MSB:gse_pkg::HI_LSB];      // see RULE_06
                  h_next     = size_reg[gse_pkg::LO_MSB:0];                    // see RULE_08
                  col_next   = 16'h0000;
                  row_next   = 16'h0000;
               end
            end
            gse_pkg::OFS_STATUS_CONFIG: begin
               cfg_next = (cfg_reg & ~wmask) | (reg_wdata & wmask);            // see RULE_03
               if (reg_be[0] && reg_wdata[gse_pkg::ST_REFUSED]) begin
                  refused_next = 1'b0;
               end
            end
            gse_pkg::OFS_LEGACY_WINDOW: begin
               window_next = (window_reg & ~wmask) | (reg_wdata & wmask);      // see RULE_12
            end
            gse_pkg::OFS_LEGACY_LATCH: begin
               latchw_next = (latch_rdata & ~wmask) | (reg_wdata & wmask);     // see RULE_13
               latchp_next = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // register reads, unmapped offsets read zero
      if (reg_rd) begin
         unique case (reg_addr)
            gse_pkg::OFS_DEST_START:    rdata_next = dest_reg;
            gse_pkg::OFS_SIZE_LENGTH:   rdata_next = size_reg;
            gse_pkg::OFS_SOURCE_ERROR:  rdata_next = source_reg;
            gse_pkg::OFS_LINE_TRIGGER:  rdata_next = line_reg;
            gse_pkg::OFS_BLOCK_TRIGGER: rdata_next = block_reg;
            gse_pkg::OFS_STATUS_CONFIG: rdata_next = status_word;              // see RULE_03
            gse_pkg::OFS_LEGACY_WINDOW: rdata_next = window_reg;               // see RULE_12
            gse_pkg::OFS_LEGACY_LATCH:  rdata_next = latch_rdata;              // see RULE_13
            default:                    rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         dest_reg    <= gse_pkg::RST_PARAM;                                    // see RULE_14
         size_reg    <= gse_pkg::RST_PARAM;
         source_reg  <= gse_pkg::RST_PARAM;
         line_reg    <= gse_pkg::RST_PARAM;
         block_reg   <= gse_pkg::RST_PARAM;
         cfg_reg     <= gse_pkg::RST_PARAM;
         refused_reg <= 1'b0;
         window_reg  <= gse_pkg::RST_LEGACY;
         latchw_reg  <= gse_pkg::RST_LEGACY;
         latchp_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rvalid_reg  <= 1'b0;
         state_reg   <= gse_pkg::GSE_IDLE;
         x_reg       <= 16'h0000;
         y_reg       <= 16'h0000;
         sx_reg      <= 16'h0000;
         sy_reg      <= 16'h0000;
         col_reg     <= 16'h0000;
         row_reg     <= 16'h0000;
         w_reg       <= 16'h0000;
         h_reg       <= 16'h0000;
         x0_reg      <= 16'h0000;
         sx0_reg     <= 16'h0000;
         err_reg     <= 16'sh0000;
         axial_reg   <= 16'h0000;
         diag_reg    <= 16'h0000;
         dir_reg     <= 3'h0;
      end else begin
         dest_reg    <= dest_next;
         size_reg    <= size_next;
         source_reg  <= source_next;
         line_reg    <= line_next;
         block_reg   <= block_next;
         cfg_reg     <= cfg_next;
         refused_reg <= refused_next;
         window_reg  <= window_next;
         latchw_reg  <= latchw_next;
         latchp_reg  <= latchp_next;
         rdata_reg   <= rdata_next;
         rvalid_reg  <= rvalid_next;
         state_reg   <= state_next;
         x_reg       <= x_next;
         y_reg       <= y_next;
         sx_reg      <= sx_next;
         sy_reg      <= sy_next;
         col_reg     <= col_next;
         row_reg     <= row_next;
         w_reg       <= w_next;
         h_reg       <= h_next;
         x0_reg      <= x0_next;
         sx0_reg     <= sx0_next;
         err_reg     <= err_next;
         axial_reg   <= axial_next;
         diag_reg    <= diag_next;
         dir_reg     <= dir_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata            = rdata_reg;
   assign reg_rvalid           = rvalid_reg;
   assign legacy_window_offset = window_reg;
   assign latch_wr_pulse       = latchp_reg;
   assign latch_wdata          = latchw_reg;
   assign pix_valid            = !idle;
   assign pix_line             = (state_reg == gse_pkg::GSE_LINE);
   assign pix_x                = x_reg;
   assign pix_y                = y_reg;
   assign pix_src_x            = sx_reg;
   assign pix_src_y            = sy_reg;

endmodule // gse_top

// File: gse_pkg.sv
// constants and types of the graphics engine setup registers
package gse_pkg;
   // ------------------------------------------------------------
   // register offsets from the graphics base
   // ------------------------------------------------------------
   localparam logic [15:0] OFS_DEST_START    = 16'h8100;
   localparam logic [15:0] OFS_SIZE_LENGTH   = 16'h8104;
   localparam logic [15:0] OFS_SOURCE_ERROR  = 16'h8108;
   localparam logic [15:0] OFS_LINE_TRIGGER  = 16'h8204;
   localparam logic [15:0] OFS_BLOCK_TRIGGER = 16'h8208;
   localparam logic [15:0] OFS_STATUS_CONFIG = 16'h820C;
   localparam logic [15:0] OFS_LEGACY_WINDOW = 16'h8210;
   localparam logic [15:0] OFS_LEGACY_LATCH  = 16'h8214;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_PARAM         = 32'h0000_0000;
   localparam logic [31:0] RST_LEGACY        = 32'h0000_0000;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int HI_MSB       = 31;
   localparam int HI_LSB       = 16;
   localparam int LO_MSB       = 15;
   localparam int LEN_MSB      = 29;
   localparam int LINE_Y_MAJOR = 0;
   localparam int LINE_X_NEG   = 1;
   localparam int LINE_Y_NEG   = 2;
   localparam int ST_BUSY      = 0;
   localparam int ST_BLOCK     = 1;
   localparam int ST_LINE      = 2;
   localparam int ST_REFUSED   = 3;
   localparam int CFG_LSB      = 8;

   // ------------------------------------------------------------
   // engine states, gray along idle -> block -> line
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      GSE_IDLE  = 2'h0,
      GSE_BLOCK = 2'h1,
      GSE_LINE  = 2'h3
   } gse_state_t;
endpackage

// File: gse_top_asserts.sv
// concurrent checks on the ports of the graphics engine setup block
`timescale 1ns/1ps
module gse_top_chk (
   input wire logic        clk_sys,              // system clock
   input wire logic        rst_n,                // reset, active low
   input wire logic [15:0] reg_addr,             // register offset
   input wire logic        reg_wr,               // write strobe
   input wire logic        reg_rd,               // read strobe
   input wire logic [3:0]  reg_be,               // byte enables
   input wire logic [31:0] reg_wdata,            // write data
   input wire logic        reg_rvalid,           // read data valid
   input wire logic [31:0] legacy_window_offset, // legacy window
   input wire logic        latch_wr_pulse,       // latch load pulse
   input wire logic        pix_valid,            // pixel valid
   input wire logic        pix_ready,            // pixel accepted
   input wire logic        pix_line,             // line pixel
   input wire logic [15:0] pix_x,                // destination x
   input wire logic [15:0] pix_src_x             // source x
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // register bus and triggers
   // ------------------------------------------------------------
   read_answer_a: assert property (reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after read");
   trig_start_a: assert property ($rose(pix_valid) |->
      $past(reg_wr && (reg_addr == gse_pkg::OFS_LINE_TRIGGER || reg_addr == gse_pkg::OFS_BLOCK_TRIGGER)))
      else $error("engine started without a trigger write");
   line_kind_a: assert property (reg_wr && reg_addr == gse_pkg::OFS_LINE_TRIGGER && !pix_valid
      |=> !pix_valid || pix_line) else $error("line trigger started a block");
   block_kind_a: assert property (reg_wr && reg_addr == gse_pkg::OFS_BLOCK_TRIGGER && !pix_valid
      |=> !pix_valid || !pix_line) else $error("block trigger started a line");

   // ------------------------------------------------------------
   // pixel stepping
   // ------------------------------------------------------------
   pix_hold_a: assert property (pix_valid && !pix_ready
      |=> pix_valid && $stable(pix_x) && $stable(pix_src_x)) else $error("pixel changed while stalled");
   src_follow_a: assert property (pix_valid && pix_ready && !pix_line |=> !pix_valid ||
      16'(pix_x - $past(pix_x)) == 16'(pix_src_x - $past(pix_src_x))) else $error("source x apart from dest x");
   line_step_a: assert property (pix_valid && pix_ready && pix_line |=> !pix_valid ||
      (16'(pix_x - $past(pix_x) + 16'h0001) <= 16'h0002 && $stable(pix_src_x))) else $error("line step too large");

   // ------------------------------------------------------------
   // legacy registers
   // ------------------------------------------------------------
   latch_pulse_a: assert property (latch_wr_pulse == $past(reg_wr && reg_addr == gse_pkg::OFS_LEGACY_LATCH))
      else $error("latch pulse not one cycle after latch write");
   window_load_a: assert property (reg_wr && reg_addr == gse_pkg::OFS_LEGACY_WINDOW && reg_be == 4'hF
      |=> legacy_window_offset == $past(reg_wdata)) else $error("window offset not loaded");
   window_keep_a: assert property (!(reg_wr && reg_addr == gse_pkg::OFS_LEGACY_WINDOW)
      |=> $stable(legacy_window_offset)) else $error("window offset changed unwritten");

   block_pix_c: cover property (pix_valid && pix_ready && !pix_line);
   line_pix_c: cover property (pix_valid && pix_ready && pix_line);
   latch_c: cover property (latch_wr_pulse);
endmodule // gse_top_chk

bind gse_top gse_top_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
   .legacy_window_offset(legacy_window_offset), .latch_wr_pulse(latch_wr_pulse), .pix_valid(pix_valid),
   .pix_ready(pix_ready), .pix_line(pix_line), .pix_x(pix_x), .pix_src_x(pix_src_x));

// File: gse_top_test.sv
// self-checking testbench of the graphics engine setup block
`timescale 1ns/1ps
module gse_top_test;
   logic        clk_sys, rst_n, reg_wr, reg_rd, pix_ready, reg_rvalid, latch_wr_pulse, pix_valid, pix_line;
   logic [15:0] reg_addr, pix_x, pix_y, pix_src_x, pix_src_y;
   logic [3:0]  reg_be;
   logic [31:0] reg_wdata, latch_rdata, reg_rdata, legacy_window_offset, latch_wdata;
   int          errors, total_checks, k;
   logic [15:0] ofs [6] = '{gse_pkg::OFS_DEST_START, gse_pkg::OFS_SIZE_LENGTH, gse_pkg::OFS_SOURCE_ERROR,
      gse_pkg::OFS_LINE_TRIGGER, gse_pkg::OFS_BLOCK_TRIGGER, gse_pkg::OFS_STATUS_CONFIG};

   gse_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .legacy_window_offset(legacy_window_offset), .latch_wr_pulse(latch_wr_pulse), .latch_wdata(latch_wdata),
      .latch_rdata(latch_rdata), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_line(pix_line),
      .pix_x(pix_x), .pix_y(pix_y), .pix_src_x(pix_src_x), .pix_src_y(pix_src_y));

   // ------------------------------------------------------------
   // bus and compare tasks, each starts and ends at a falling edge
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_be = be;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk({what, " valid"}, 32'h1, {31'h0, reg_rvalid});
      chk(what, exp, reg_rdata);
   endtask
   // waits for a pixel, checks it and accepts it
   task automatic pix(input logic [15:0] x, input logic [15:0] y, input logic [15:0] sx, input logic [15:0] sy,
      input logic ln);
      @(negedge clk_sys);
      for (k = 0; k < 20 && pix_valid !== 1'b1; k++) @(negedge clk_sys);
      if (pix_valid !== 1'b1) begin
         errors++;
         $display("ERROR pixel wait expected 1 seen %b", pix_valid);
         print_verdict();
      end
      chk("pixel", {x, y}, {pix_x, pix_y});
      chk("kind", {31'h0, ln}, {31'h0, pix_line});
      if (!ln) chk("source", {sx, sy}, {pix_src_x, pix_src_y});
      pix_ready = 1'b1;
      @(negedge clk_sys);
      pix_ready = 1'b0;
   endtask
   task automatic idle(input string what);
      repeat (4) @(negedge clk_sys);
      chk(what, 32'h0, {31'h0, pix_valid});
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   initial begin
      {rst_n, reg_wr, reg_rd, pix_ready, reg_addr, reg_be, reg_wdata} = '0;
      latch_rdata = 32'h1122_3344;
      errors = 0;
      total_checks = 0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      foreach (ofs[i]) rd(ofs[i], 32'h0, "reset value");
      rd(16'h8300, 32'h0, "unmapped");
      $display("test reset done");
      // block transfer with negative destination crossing zero
      wr(gse_pkg::OFS_DEST_START, 32'hFFFE_FFFF, 4'hF);
      wr(gse_pkg::OFS_SIZE_LENGTH, 32'h0002_0002, 4'hF);
      wr(gse_pkg::OFS_SOURCE_ERROR, 32'h0001_0003, 4'hF);
      wr(gse_pkg::OFS_BLOCK_TRIGGER, 32'h0, 4'hF);
      rd(gse_pkg::OFS_STATUS_CONFIG, 32'h0000_0003, "status block");
      wr(gse_pkg::OFS_BLOCK_TRIGGER, 32'h0, 4'hF);
      rd(gse_pkg::OFS_STATUS_CONFIG, 32'h0000_000B, "status refused");
      pix(16'hFFFF, 16'hFFFE, 16'h0001, 16'h0003, 1'b0);
      pix(16'h0000, 16'hFFFE, 16'h0002, 16'h0003, 1'b0);
      pix(16'hFFFF, 16'hFFFF, 16'h0001, 16'h0004, 1'b0);
      pix(16'h0000, 16'hFFFF, 16'h0002, 16'h0004, 1'b0);
      idle("block end");
      wr(gse_pkg::OFS_STATUS_CONFIG, 32'h8, 4'h1);
      rd(gse_pkg::OFS_DEST_START, 32'hFFFE_FFFF, "dest kept");
      rd(gse_pkg::OFS_SOURCE_ERROR, 32'h0001_0003, "source kept");
      $display("test block done");
      wr(gse_pkg::OFS_SIZE_LENGTH, 32'h0000_0003, 4'hF);
      wr(gse_pkg::OFS_BLOCK_TRIGGER, 32'h0, 4'hF);
      idle("zero width");
      wr(gse_pkg::OFS_SIZE_LENGTH, 32'h0003_0000, 4'hF);
      wr(gse_pkg::OFS_BLOCK_TRIGGER, 32'h0, 4'hF);
      idle("zero height");
      $display("test zero size done");
      // line of length 3, reserved length bits set, initial error -1
      wr(gse_pkg::OFS_DEST_START, 32'h0, 4'hF);
      wr(gse_pkg::OFS_SIZE_LENGTH, 32'hC003_FFFF, 4'hF);
      wr(gse_pkg::OFS_SOURCE_ERROR, 32'h0001_FFFE, 4'hF);
      wr(gse_pkg::OFS_LINE_TRIGGER, 32'h0, 4'hF);
      rd(gse_pkg::OFS_STATUS_CONFIG, 32'h0000_0005, "status line");
      pix(16'h0000, 16'h0000, 16'h0, 16'h0, 1'b1);
      pix(16'h0001, 16'h0000, 16'h0, 16'h0, 1'b1);
      pix(16'h0002, 16'h0001, 16'h0, 16'h0, 1'b1);
      idle("line end");
      wr(gse_pkg::OFS_SIZE_LENGTH, 32'h0002_0000, 4'hF);
      wr(gse_pkg::OFS_LINE_TRIGGER, 32'h7, 4'hF);
      pix(16'h0000, 16'h0000, 16'h0, 16'h0, 1'b1);
      pix(16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 1'b1);
      idle("line back");
      $display("test line done");
      wr(gse_pkg::OFS_STATUS_CONFIG, 32'hFFFF_FFF7, 4'hF);
      rd(gse_pkg::OFS_STATUS_CONFIG, 32'hFFFF_FF00, "status config");
      $display("test status done");
      wr(gse_pkg::OFS_LEGACY_WINDOW, 32'h00A5_5000, 4'hF);
      chk("window port", 32'h00A5_5000, legacy_window_offset);
      rd(gse_pkg::OFS_LEGACY_WINDOW, 32'h00A5_5000, "window");
      wr(gse_pkg::OFS_LEGACY_LATCH, 32'hAABB_CCDD, 4'h3);
      chk("latch pulse", 32'h1, {31'h0, latch_wr_pulse});
      chk("latch data", 32'h1122_CCDD, latch_wdata);
      rd(gse_pkg::OFS_LEGACY_LATCH, 32'h1122_3344, "latch read");
      $display("test legacy done");
      print_verdict();
   end
endmodule // gse_top_test
